// ---- shared/trwg_pkg.sv ----
// constants for the random word generator
package trwg_pkg;
   localparam int unsigned CLK_HZ          = 20000000;
   localparam int unsigned ADDR_W          = 24;
   localparam logic [23:0] CST_ADDR        = 24'hfff280;
   localparam logic [23:0] DATA_ADDR       = 24'hfff282;
   localparam logic [23:0] DIVH_ADDR       = 24'hfff284;
   localparam logic [23:0] DIVL_ADDR       = 24'hfff286;
   localparam logic [23:0] IRQ_STAT_ADDR   = 24'hfff288;
   localparam logic [23:0] IRQ_EN_ADDR     = 24'hfff28c;
   localparam logic [23:0] IRQ_CLR_ADDR    = 24'hfff290;
   localparam int unsigned ENABLE_BIT      = 0;
   localparam int unsigned VALID_BIT       = 1;
   localparam int unsigned IRQ_EN_BIT      = 5;
   localparam logic [15:0] CST_RESET       = 16'h0000;
   localparam logic [15:0] DIVH_RESET      = 16'h0000;
   localparam logic [15:0] DIVL_RESET      = 16'h83d6;
   localparam int unsigned DIV_W           = 18;
   localparam int unsigned WORD_W          = 16;
   localparam int unsigned MAX_STROBE_HZ   = 800;
   localparam logic [1:0]  RESP_OKAY       = 2'b00;
   localparam logic [1:0]  RESP_SLVERR     = 2'b10;
   typedef enum logic [1:0] {
      TRWG_IDLE = 2'b00,
      TRWG_RUN  = 2'b01
   } trwg_div_state_t;
endpackage : trwg_pkg

// ---- rtl/trwg_sampler.sv ----
// entropy resync, strobe divider and 16-bit word assembler
`timescale 1ns/100ps
module trwg_sampler (
   // clock and reset
   input  wire logic                       clock_i,
   input  wire logic                       rst_i,
   // control
   input  wire logic                       enable_i,
   input  wire logic [trwg_pkg::DIV_W-1:0] divisor_i,
   input  wire logic                       entropy_i,
   // completed word
   output logic                            word_done_o,
   output logic [trwg_pkg::WORD_W-1:0]     word_o
);
   import trwg_pkg::*;

   logic                  sync1_r;
   logic                  sync2_r;
   logic [DIV_W-1:0]      count_r;
   logic                  strobe_r;
   logic [WORD_W-1:0]     shift_r;
   logic [3:0]            bits_r;
   trwg_div_state_t       state_r;

   // two stages, oscillators live outside this clock
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= entropy_i;
         sync2_r <= sync1_r; // RULE_16
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state_r  <= TRWG_IDLE;
         count_r  <= '0;
         strobe_r <= 1'b0;
      end else begin
         strobe_r <= 1'b0;
         case (state_r)
            TRWG_IDLE: begin
               count_r <= '0;
               if (enable_i) begin
                  state_r <= TRWG_RUN;
               end
            end
            TRWG_RUN: begin
               if (!enable_i) begin
                  state_r <= TRWG_IDLE;
               // zero divisor treated as one to avoid a stuck counter
               end else if (count_r + 18'h00001 >= divisor_i) begin
                  count_r  <= '0; // RULE_15
                  strobe_r <= 1'b1; // RULE_08
               end else begin
                  count_r <= count_r + 18'h00001;
               end
            end
            default: state_r <= TRWG_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         shift_r     <= '0;
         bits_r      <= '0;
         word_done_o <= 1'b0;
         word_o      <= '0;
      end else begin
         word_done_o <= 1'b0;
         if (!enable_i) begin
            bits_r <= '0;
         end else if (strobe_r) begin
            shift_r <= {shift_r[WORD_W-2:0], sync2_r}; // RULE_13
            bits_r  <= bits_r + 4'h1;
            if (bits_r == 4'hf) begin
               word_o      <= {shift_r[WORD_W-2:0], sync2_r};
               word_done_o <= 1'b1;
            end
         end
      end
   end
endmodule : trwg_sampler

// ---- rtl/trwg_top.sv ----
// random word generator with axi4-lite register slave
// How it works
// RULE_01: reset clears control and status register
// RULE_02: enable bit low halts generator and oscillators
// RULE_03: valid bit shows fresh word, clears on read
// RULE_04: irq mask bit gates the word interrupt; here it gates the valid path only, not the stat_en_r sticky path
// RULE_05: data read returns word then clears it
// RULE_06: new word sets valid and raises interrupt
// RULE_07: divisor is 18 bits over two registers
// RULE_08: system clock divided gives sampling strobe
// RULE_09: software keeps strobe rate at most 800 Hz
// RULE_10: divisor resets to its default value
// RULE_11: fast oscillator steps lfsr continuously
// RULE_12: slow unstable oscillator samples lfsr stream
// RULE_13: sampled bits shift into 16-bit register
// RULE_14: halt input stops clear on data read
// RULE_15: divider counts, strobes and reloads at divisor
// RULE_16: entropy input resynchronised before shifting
`timescale 1ns/100ps
module trwg_top (
   // clock and reset
   input  wire logic                        clock_i,
   input  wire logic                        rst_i,
   // entropy and emulator halt
   input  wire logic                        entropy_i,
   input  wire logic                        halt_i,
   // oscillator run request
   output logic                             osc_run_o,
   // interrupt
   output logic                             random_word_irq_o,
   // axi4-lite write address
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [trwg_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]                  s_axi_awprot,
   // axi4-lite write data
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   // axi4-lite write response
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   output logic [1:0]                       s_axi_bresp,
   // axi4-lite read address
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   input  wire logic [trwg_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]                  s_axi_arprot,
   // axi4-lite read data
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp
);
   import trwg_pkg::*;

   logic                  halt_s1_r;
   logic                  halt_s2_r;
   logic                  enable_r;
   logic                  valid_r;
   logic                  irq_en_r;
   logic [WORD_W-1:0]     data_r;
   logic [1:0]            divh_r;
   logic [WORD_W-1:0]     divl_r;
   logic                  stat_r;
   logic                  stat_en_r;
   logic                  aw_full_r;
   logic                  w_full_r;
   logic [ADDR_W-1:0]     aw_addr_r;
   logic [31:0]           w_data_r;
   logic [3:0]            w_strb_r;
   logic                  wr_go;
   logic                  rd_go;
   logic                  rd_data_hit;
   logic                  rd_clear;
   logic                  word_done;
   logic [WORD_W-1:0]     word;

   // register address decode, byte lanes 0 and 1 only
   function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] r);
      return a == r;
   endfunction : is_reg

   function automatic logic known(input logic [ADDR_W-1:0] a);
      return is_reg(a, CST_ADDR) || is_reg(a, DATA_ADDR) ||
             is_reg(a, DIVH_ADDR) || is_reg(a, DIVL_ADDR) ||
             is_reg(a, IRQ_STAT_ADDR) || is_reg(a, IRQ_EN_ADDR) ||
             is_reg(a, IRQ_CLR_ADDR);
   endfunction : known

   // emulator halt is asynchronous to this clock
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         halt_s1_r <= 1'b0;
         halt_s2_r <= 1'b0;
      end else begin
         halt_s1_r <= halt_i;
         halt_s2_r <= halt_s1_r;
      end
   end

   trwg_sampler u_sampler (
      .clock_i     (clock_i),
      .rst_i       (rst_i),
      .enable_i    (enable_r),
      .divisor_i   ({divh_r, divl_r}),
      .entropy_i   (entropy_i),
      .word_done_o (word_done),
      .word_o      (word)
   );

   // write channel capture, either order
   assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;

   // address half; ready rests low after every take until the pair is written
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         aw_full_r     <= 1'b0;
         aw_addr_r     <= '0;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_full_r && !(s_axi_awvalid && s_axi_awready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (wr_go) begin
            aw_full_r <= 1'b0;
         end
      end
   end

   // data half, held with its strobes until the address arrives
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         w_full_r     <= 1'b0;
         w_data_r     <= '0;
         w_strb_r     <= '0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_full_r && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            w_full_r <= 1'b0;
         end
      end
   end

   // response; a held bvalid stalls the next pair, one write in flight
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= known(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read channel, one cycle to answer
   assign rd_go       = s_axi_arvalid && s_axi_arready;
   assign rd_data_hit = rd_go && is_reg(s_axi_araddr, DATA_ADDR);
   assign rd_clear    = rd_data_hit && !halt_s2_r; // RULE_14

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !rd_go;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // read word; unused and write-only bits read as zero
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_rdata <= '0;
      end else begin
         if (rd_go) begin
            s_axi_rdata <= '0;
            if (is_reg(s_axi_araddr, CST_ADDR)) begin
               s_axi_rdata[IRQ_EN_BIT] <= irq_en_r;
               s_axi_rdata[VALID_BIT]  <= valid_r; // RULE_03
               s_axi_rdata[ENABLE_BIT] <= enable_r;
            end else if (is_reg(s_axi_araddr, DATA_ADDR)) begin
               s_axi_rdata[WORD_W-1:0] <= data_r; // RULE_05
            end else if (is_reg(s_axi_araddr, DIVH_ADDR)) begin
               s_axi_rdata[1:0] <= divh_r;
            end else if (is_reg(s_axi_araddr, DIVL_ADDR)) begin
               s_axi_rdata[WORD_W-1:0] <= divl_r;
            end else if (is_reg(s_axi_araddr, IRQ_STAT_ADDR)) begin
               s_axi_rdata[0] <= stat_r;
            end else if (is_reg(s_axi_araddr, IRQ_EN_ADDR)) begin
               s_axi_rdata[0] <= stat_en_r;
            end
         end
      end
   end

   // control bits; only byte lane 0 carries them
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         enable_r <= CST_RESET[ENABLE_BIT]; // RULE_01
         irq_en_r <= CST_RESET[IRQ_EN_BIT];
      end else if (wr_go && is_reg(aw_addr_r, CST_ADDR) && w_strb_r[0]) begin
         enable_r <= w_data_r[ENABLE_BIT]; // RULE_02
         irq_en_r <= w_data_r[IRQ_EN_BIT];
      end
   end

   // rule 09 is software's: no clamp on a too-small divisor
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         divh_r <= DIVH_RESET[1:0]; // RULE_10
      end else if (wr_go && is_reg(aw_addr_r, DIVH_ADDR) && w_strb_r[0]) begin
         divh_r <= w_data_r[1:0]; // RULE_07
      end
   end

   // low divisor takes each byte lane on its own
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         divl_r <= DIVL_RESET; // RULE_10
      end else if (wr_go && is_reg(aw_addr_r, DIVL_ADDR)) begin
         if (w_strb_r[0]) begin
            divl_r[7:0] <= w_data_r[7:0]; // RULE_07
         end
         if (w_strb_r[1]) begin
            divl_r[15:8] <= w_data_r[15:8];
         end
      end
   end

   // sticky event enable
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         stat_en_r <= 1'b0;
      end else if (wr_go && is_reg(aw_addr_r, IRQ_EN_ADDR) &&
                   w_strb_r[0]) begin
         stat_en_r <= w_data_r[0];
      end
   end

   // data word; new word wins over a clearing read
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         data_r <= '0;
      end else if (word_done) begin
         data_r <= word;
      end else if (rd_clear) begin
         data_r <= '0; // RULE_05
      end
   end

   // valid flag; set wins so a word landing under a read is kept
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         valid_r <= CST_RESET[VALID_BIT];
      end else if (word_done) begin
         valid_r <= 1'b1; // RULE_06
      end else if (rd_clear) begin
         valid_r <= 1'b0; // RULE_03
      end
   end

   // sticky word event, write-one clear, set wins
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         stat_r <= 1'b0;
      end else if (word_done) begin
         stat_r <= 1'b1;
      end else if (wr_go && is_reg(aw_addr_r, IRQ_CLR_ADDR) &&
                   w_strb_r[0] && w_data_r[0]) begin
         stat_r <= 1'b0;
      end
   end

   // irq follows valid as the mask bit allows, plus the sticky path
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         random_word_irq_o <= 1'b0;
      end else begin
         random_word_irq_o <= (valid_r && irq_en_r) || // RULE_04
                              (stat_r && stat_en_r);
      end
   end

   // the oscillators sit outside; they only see this run request
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         osc_run_o <= 1'b0;
      end else begin
         osc_run_o <= enable_r; // RULE_11 RULE_12
      end
   end
endmodule : trwg_top

// ---- sim/trwg_sva.sv ----
// bus and interrupt assertions for the random word generator
`timescale 1ns/100ps
module trwg_chk (
   // clock and reset
   input wire logic                        clock_i,
   input wire logic                        rst_i,
   // generator outputs
   input wire logic                        osc_run_o,
   input wire logic                        random_word_irq_o,
   // axi4-lite handshakes
   input wire logic                        s_axi_awvalid,
   input wire logic                        s_axi_awready,
   input wire logic                        s_axi_wvalid,
   input wire logic                        s_axi_wready,
   input wire logic                        s_axi_bvalid,
   input wire logic                        s_axi_bready,
   input wire logic [1:0]                  s_axi_bresp,
   input wire logic                        s_axi_arvalid,
   input wire logic                        s_axi_arready,
   input wire logic [trwg_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic                        s_axi_rvalid,
   input wire logic                        s_axi_rready,
   input wire logic [31:0]                 s_axi_rdata,
   input wire logic [1:0]                  s_axi_rresp
);
   import trwg_pkg::*;
   logic [ADDR_W-1:0] rd_addr_r;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // read answer is judged against the address taken, not the live bus
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i)
         rd_addr_r <= '0;
      else if (s_axi_arvalid && s_axi_arready)
         rd_addr_r <= s_axi_araddr;
   end
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return a inside {CST_ADDR, DATA_ADDR, DIVH_ADDR, DIVL_ADDR,
                       IRQ_STAT_ADDR, IRQ_EN_ADDR, IRQ_CLR_ADDR};
   endfunction : mapped
   rst_clear_a: assert property ($fell(rst_i) |->
      !osc_run_o && !random_word_irq_o) else $error("outputs set at reset");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read answer late");
   rd_hold_a: assert property (s_axi_rvalid && s_axi_rready
      |=> !s_axi_rvalid) else $error("read answer repeated");
   wr_hold_a: assert property (s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid) else $error("write answer repeated");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   aw_take_a: assert property (s_axi_awvalid && s_axi_awready
      |=> !s_axi_awready) else $error("awready held after take");
   w_take_a: assert property (s_axi_wvalid && s_axi_wready
      |=> !s_axi_wready) else $error("wready held after take");
   rd_upper_a: assert property (s_axi_rvalid
      |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper rdata set");
   rd_unmap_a: assert property (s_axi_rvalid && !mapped(rd_addr_r)
      |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read answered");
   irq_c: cover property ($rose(random_word_irq_o));
   osc_c: cover property ($rose(osc_run_o));
   err_c: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : trwg_chk
bind trwg_top trwg_chk i_chk (.clock_i, .rst_i, .osc_run_o,
   .random_word_irq_o, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
   .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

// ---- sim/tb.sv ----
// self-checking bench for the random word generator
`timescale 1ns/100ps
module tb;
   import trwg_pkg::*;
   logic        clock_i = 1'b0, rst_i = 1'b1;
   logic        entropy_i = 1'b0, halt_i = 1'b0;
   logic        osc_run_o, random_word_irq_o;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [23:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [33:0] rq[$];
   logic [1:0]  bq[$];
   int          errors = 0, compares = 0;
   always #25 clock_i = ~clock_i;
   trwg_top i_dut (.clock_i, .rst_i, .entropy_i, .halt_i, .osc_run_o,
      .random_word_irq_o, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_awprot(3'b000), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
      .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
      .s_axi_arprot(3'b000), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
      .s_axi_rresp);
   task automatic fail(input string m);
      errors++;
      $display("[ERR] %0t %s", $time, m);
   endtask : fail
   task automatic cmp_bit(input logic g, input logic e);
      compares++;
      if (g !== e) fail("output bit mismatch");
   endtask : cmp_bit
   task automatic cmp_rd(input logic [33:0] g, input logic [33:0] e);
      compares++;
      if (g !== e) fail("read data or response mismatch");
   endtask : cmp_rd
   task automatic cmp_b(input logic [1:0] g, input logic [1:0] e);
      compares++;
      if (g !== e) fail("write response mismatch");
   endtask : cmp_b
   // answers are taken at the falling edge, where registered outputs rest
   always @(negedge clock_i) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
         cmp_rd({s_axi_rresp, s_axi_rdata}, rq.pop_front());
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
         cmp_b(s_axi_bresp, bq.pop_front());
   end
   task automatic wr(input logic [23:0] a, input logic [15:0] d,
                     input logic [1:0] e);
      logic aw, w, b;
      @(posedge clock_i);
      bq.push_back(e);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(negedge clock_i);
         aw = s_axi_awvalid & s_axi_awready;
         w  = s_axi_wvalid & s_axi_wready;
         b  = s_axi_bvalid & s_axi_bready;
         @(posedge clock_i);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (b) s_axi_bready <= 1'b0;
      end
   endtask : wr
   task automatic rd(input logic [23:0] a, input logic [15:0] d,
                     input logic [1:0] e);
      logic ar, r;
      @(posedge clock_i);
      rq.push_back({e, 16'h0000, d});
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      r = 1'b0;
      while (!r) begin
         @(negedge clock_i);
         ar = s_axi_arvalid & s_axi_arready;
         r  = s_axi_rvalid & s_axi_rready;
         @(posedge clock_i);
         if (ar) s_axi_arvalid <= 1'b0;
         if (r) s_axi_rready <= 1'b0;
      end
   endtask : rd
   task automatic wait_irq;
      int n;
      n = 0;
      while (random_word_irq_o !== 1'b1 && n < 400) begin
         @(negedge clock_i);
         n++;
      end
      cmp_bit(random_word_irq_o, 1'b1);
   endtask : wait_irq
   task automatic close_out;
      if (errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : close_out
   initial begin
      repeat (20000) @(posedge clock_i);
      fail("watchdog expired");
      close_out();
   end
   initial begin
      logic [15:0] rnd;
      logic        b;
      void'($urandom(32'hb9811f3f));
      rnd = 16'($urandom());
      b   = 1'($urandom());
      repeat (4) @(posedge clock_i);
      rst_i <= 1'b0;
      rd(CST_ADDR, 16'h0000, RESP_OKAY);
      rd(DIVH_ADDR, 16'h0000, RESP_OKAY);
      rd(DIVL_ADDR, 16'h83d6, RESP_OKAY);
      rd(DATA_ADDR, 16'h0000, RESP_OKAY);
      rd(24'hfff2a0, 16'h0000, RESP_SLVERR);
      wr(24'hfff2a0, rnd, RESP_SLVERR);
      wr(DIVH_ADDR, 16'hffff, RESP_OKAY);
      wr(DIVL_ADDR, rnd, RESP_OKAY);
      rd(DIVH_ADDR, 16'h0003, RESP_OKAY);
      rd(DIVL_ADDR, rnd, RESP_OKAY);
      wr(DIVL_ADDR, 16'(CLK_HZ / MAX_STROBE_HZ), RESP_OKAY);
      rd(DIVL_ADDR, 16'(CLK_HZ / MAX_STROBE_HZ), RESP_OKAY);
      wr(DIVH_ADDR, 16'h0000, RESP_OKAY);
      wr(DIVL_ADDR, 16'h0002, RESP_OKAY);
      // steady entropy makes the whole word predictable
      entropy_i <= b;
      wr(CST_ADDR, 16'h0021, RESP_OKAY);
      @(negedge clock_i);
      cmp_bit(osc_run_o, 1'b1);
      wait_irq();
      wr(CST_ADDR, 16'h0020, RESP_OKAY);
      @(negedge clock_i);
      cmp_bit(osc_run_o, 1'b0);
      rd(CST_ADDR, 16'h0022, RESP_OKAY);
      rd(DATA_ADDR, {16{b}}, RESP_OKAY);
      repeat (100) @(posedge clock_i);
      rd(CST_ADDR, 16'h0020, RESP_OKAY);
      rd(DATA_ADDR, 16'h0000, RESP_OKAY);
      @(negedge clock_i);
      cmp_bit(random_word_irq_o, 1'b0);
      wr(IRQ_CLR_ADDR, 16'h0001, RESP_OKAY);
      wr(IRQ_EN_ADDR, 16'h0001, RESP_OKAY);
      entropy_i <= ~b;
      wr(CST_ADDR, 16'h0001, RESP_OKAY);
      wait_irq();
      wr(CST_ADDR, 16'h0000, RESP_OKAY);
      halt_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      rd(DATA_ADDR, {16{~b}}, RESP_OKAY);
      rd(DATA_ADDR, {16{~b}}, RESP_OKAY);
      rd(CST_ADDR, 16'h0002, RESP_OKAY);
      rd(IRQ_STAT_ADDR, 16'h0001, RESP_OKAY);
      wr(IRQ_CLR_ADDR, 16'h0001, RESP_OKAY);
      halt_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      @(negedge clock_i);
      cmp_bit(random_word_irq_o, 1'b0);
      rd(DATA_ADDR, {16{~b}}, RESP_OKAY);
      rd(DATA_ADDR, 16'h0000, RESP_OKAY);
      rd(CST_ADDR, 16'h0000, RESP_OKAY);
      close_out();
   end
endmodule : tb
